// file: core/conv_pkg.sv
/*
  Shared constants for the successive-approximation converter control block:
  register indexes, field positions, reset values, divider and timing counts.
  Assumes a 10 MHz pclk and a 32-bit APB register bus.
*/
// Overview of operation
// RL1 - Input above upper reference gives result all ones, high FFh, low 03h, no overflow.
// RL2 - Input below lower reference gives an all-zero result in both result registers.
// RL3 - Setting converter_on starts repeated conversions of the selected input without help.
// RL4 - Clearing converter_on powers the converter down and stops any conversion.
// RL5 - Each finished conversion loads the result registers and sets the done flag.
// RL6 - Reading the high result or writing the control register clears the done flag.
// RL7 - Results are not latched; software reads both before the next conversion ends.
// RL8 - Changing input_select aborts the conversion, clears done and restarts at once.
// RL9 - Clock-rate bit selects converter clock: 0 gives pclk over 4, 1 over 2.
// RL10 - The 4-bit input_select field picks inputs 0 to 15 as a binary number.
// RL11 - Software always writes zero to the reserved control bit.
// RL12 - High result register shows result bits nine down to two.
// RL13 - Low result register shows bits one and zero; upper six bits read zero.
// RL14 - Full result: poll done, read low, then high; the high read clears done.
// RL15 - Eight-bit result: poll done, read only high; that read clears done.
// RL16 - Halt disables the converter; a stabilisation wait follows wakeup before converting.
// RL17 - Wait mode leaves converter operation and register behaviour unchanged.
// RL18 - After reset the control register is all zero: off, divide by four, input 0.
// RL19 - Sequencer samples for a fixed interval then resolves one bit per converter clock.
// RL20 - No interrupt is raised; software polls the done flag.
package conv_pkg;

  // Register indexes; byte address is four times the index
  localparam logic [9:0] IDX_CTRL = 10'h070;
  localparam logic [9:0] IDX_HIGH = 10'h071;
  localparam logic [9:0] IDX_LOW = 10'h072;

  // Control/status field positions
  localparam int DONE_BIT = 7;
  localparam int SPEED_BIT = 6;
  localparam int ON_BIT = 5;
  localparam int SEL_MSB = 3;
  localparam int SEL_W = 4;
  localparam int RES_W = 10;

  // Reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [RES_W-1:0] RESULT_RESET = 10'h000;

  // Converter clock: last count of the pclk divider
  localparam logic [1:0] DIV4_LAST = 2'h3;
  localparam logic [1:0] DIV2_LAST = 2'h1;

  // Sampling interval in converter clocks, and first trial code
  localparam logic [1:0] SAMPLE_LAST = 2'h2;
  localparam logic [RES_W-1:0] TRIAL_MSB = 10'h200;
  localparam logic [3:0] BIT_TOP = 4'h9;

  // Stabilisation after leaving halt, least time rounded up
  localparam int CLK_PERIOD_NS = 100;
  localparam int T_STAB_NS = 30000;
  localparam int STAB_CYCLES = (T_STAB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [8:0] STAB_LOAD = 9'(STAB_CYCLES);

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_SAMPLE = 2'b01,
    SEQ_CONVERT = 2'b10
  } seq_state_t;

  // APB word index of a byte address
  function automatic logic [9:0] word_index(input logic [11:0] addr);
    word_index = addr[11:2];
  endfunction

endpackage

// file: core/sar_sequencer.sv
/*
  Successive-approximation sequencer: sampling interval, then one result bit
  per converter clock tick, most significant first, repeated while run is high.
  Assumes comp_above is produced on pclk by the analog macro, so it needs no
  synchroniser, and reflects dac_code within one pclk cycle.
*/
`timescale 1ns/1ps
module sar_sequencer
  import conv_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tick,
  input wire logic run,
  input wire logic restart,
  input wire logic comp_above,
  output logic sample_hold,
  output logic [RES_W-1:0] dac_code,
  output logic conv_done,
  output logic [RES_W-1:0] result
);

  seq_state_t state_q;
  logic [1:0] samp_cnt_q;
  logic [3:0] bit_q;
  logic [RES_W-1:0] kept;

  // Trial bit survives only if the input is at or above the trial level
  always_comb begin
    kept = dac_code;
    if (!comp_above) begin
      kept[bit_q] = 1'b0;
    end
  end

  // Sequencer; a stopped converter drops its state and trial code but keeps the result, so power-up starts clean
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= SEQ_IDLE;
      samp_cnt_q <= 2'h0;
      bit_q <= BIT_TOP;
      dac_code <= RESULT_RESET;
      conv_done <= 1'b0;
      result <= RESULT_RESET;
    end else begin
      conv_done <= 1'b0;
      if (!run) begin // [RL4]
        state_q <= SEQ_IDLE;
        samp_cnt_q <= 2'h0;
        dac_code <= RESULT_RESET;
      end else if (restart) begin // [RL8]
        state_q <= SEQ_SAMPLE;
        samp_cnt_q <= 2'h0;
        dac_code <= RESULT_RESET;
      end else if (tick) begin
        case (state_q)
          SEQ_IDLE: begin
            state_q <= SEQ_SAMPLE;
            samp_cnt_q <= 2'h0;
          end
          SEQ_SAMPLE: begin // [RL19]
            if (samp_cnt_q == SAMPLE_LAST) begin
              state_q <= SEQ_CONVERT;
              bit_q <= BIT_TOP;
              dac_code <= TRIAL_MSB;
            end else begin
              samp_cnt_q <= samp_cnt_q + 2'h1;
            end
          end
          SEQ_CONVERT: begin // [RL19] [RL1] [RL2]
            if (bit_q == 4'h0) begin
              result <= kept;
              conv_done <= 1'b1;
              state_q <= SEQ_SAMPLE; // [RL3]
              samp_cnt_q <= 2'h0;
              dac_code <= RESULT_RESET;
            end else begin
              dac_code <= kept | (TRIAL_MSB >> (BIT_TOP - bit_q + 4'h1));
              bit_q <= bit_q - 4'h1;
            end
          end
          default: begin
            state_q <= SEQ_IDLE;
          end
        endcase
      end
    end
  end

  assign sample_hold = (state_q == SEQ_SAMPLE);

endmodule

// file: core/sar_adc_control.sv
/*
  Control and result logic of the 10-bit converter: APB register slave,
  converter clock divider, halt stabilisation wait, done flag and result hold.
  Assumes an analog macro outside that drives comp_above on pclk, and a power
  manager that drives halt_mode synchronously to pclk.
*/
`timescale 1ns/1ps
module sar_adc_control
  import conv_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic halt_mode,
  input wire logic comp_above,
  output logic converter_power,
  output logic [SEL_W-1:0] input_select,
  output logic sample_hold,
  output logic [RES_W-1:0] dac_code
);

  logic on_q;
  logic speed_q;
  logic [SEL_W-1:0] sel_q;
  logic done_q;
  logic [RES_W-1:0] res_q;
  logic [7:0] rdata_q;
  logic [1:0] div_cnt_q;
  logic [8:0] stab_cnt_q;
  logic setup;
  logic access;
  logic hit_ctrl;
  logic hit_high;
  logic hit_low;
  logic mapped;
  logic wr_ctrl;
  logic rd_high;
  logic chan_change;
  logic running;
  logic tick;
  logic conv_done;
  logic [RES_W-1:0] seq_result;
  logic [7:0] rd_mux;

  // Address decode; each register is one aligned word
  always_comb begin
    hit_ctrl = 1'b0;
    hit_high = 1'b0;
    hit_low = 1'b0;
    if (word_index(paddr) == IDX_CTRL) begin
      hit_ctrl = 1'b1;
    end else if (word_index(paddr) == IDX_HIGH) begin
      hit_high = 1'b1;
    end else if (word_index(paddr) == IDX_LOW) begin
      hit_low = 1'b1;
    end
  end

  assign mapped = hit_ctrl | hit_high | hit_low;
  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign wr_ctrl = access & pwrite & hit_ctrl;
  assign rd_high = access & ~pwrite & hit_high;
  assign chan_change = wr_ctrl & (pwdata[SEL_MSB:0] != sel_q);

  // Zero-wait slave; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = access & ~mapped;
  assign prdata = {24'h000000, rdata_q};

  // Read mux; reserved and unused bits read zero
  always_comb begin
    rd_mux = 8'h00;
    if (hit_ctrl) begin
      rd_mux[DONE_BIT] = done_q;
      rd_mux[SPEED_BIT] = speed_q;
      rd_mux[ON_BIT] = on_q;
      rd_mux[SEL_MSB:0] = sel_q;
    end else if (hit_high) begin
      rd_mux = res_q[RES_W-1:2]; // [RL12]
    end else if (hit_low) begin
      rd_mux = {6'h00, res_q[1:0]}; // [RL13]
    end
  end

  // Read data is captured in the setup phase so prdata comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= 8'h00;
    end else if (setup & ~pwrite) begin
      rdata_q <= rd_mux;
    end
  end

  // Control fields; the reserved bit is not stored, so it always reads zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin // [RL18]
      on_q <= CTRL_RESET[ON_BIT];
      speed_q <= CTRL_RESET[SPEED_BIT];
      sel_q <= CTRL_RESET[SEL_MSB:0];
    end else if (wr_ctrl) begin
      on_q <= pwdata[ON_BIT]; // [RL3] [RL4]
      speed_q <= pwdata[SPEED_BIT]; // [RL9]
      sel_q <= pwdata[SEL_MSB:0]; // [RL10]
    end
  end

  // Done flag: a finishing conversion wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_q <= CTRL_RESET[DONE_BIT];
    end else if (conv_done) begin // [RL5]
      done_q <= 1'b1;
    end else if (wr_ctrl | rd_high) begin // [RL6] [RL8]
      done_q <= 1'b0;
    end
  end

  // Result is overwritten by every conversion, no shadow copy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res_q <= RESULT_RESET;
    end else if (conv_done) begin // [RL5] [RL7]
      res_q <= seq_result;
    end
  end

  // Halt powers down; the wait restarts on every halt so short halts are covered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stab_cnt_q <= 9'h000;
    end else if (halt_mode) begin // [RL16]
      stab_cnt_q <= STAB_LOAD;
    end else if (stab_cnt_q != 9'h000) begin
      stab_cnt_q <= stab_cnt_q - 9'h001;
    end
  end

  // Wait mode has no input here on purpose: the converter cannot tell it apart [RL17]
  assign converter_power = on_q & ~halt_mode; // [RL4] [RL16]
  assign running = converter_power & (stab_cnt_q == 9'h000);
  assign input_select = sel_q;

  // Converter clock as a tick; divider held at zero while stopped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_q <= 2'h0;
    end else if (!running | tick) begin
      div_cnt_q <= 2'h0;
    end else begin
      div_cnt_q <= div_cnt_q + 2'h1;
    end
  end

  assign tick = running & (div_cnt_q == (speed_q ? DIV2_LAST : DIV4_LAST)); // [RL9]

  // Completion is only visible through the done flag; no interrupt output [RL20]
  sar_sequencer u_seq (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick),
    .run(running),
    .restart(chan_change),
    .comp_above(comp_above),
    .sample_hold(sample_hold),
    .dac_code(dac_code),
    .conv_done(conv_done),
    .result(seq_result)
  );

  // Checks on the block's own behaviour
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  done_set_a: assert property (conv_done |=> done_q && res_q == $past(seq_result)) // [RL5]
    else $error("done flag or result not loaded after conversion");

  high_read_clear_a: assert property (rd_high && !conv_done |=> !done_q) // [RL6]
    else $error("high result read did not clear done");

  ctrl_write_clear_a: assert property (wr_ctrl && !conv_done |=> !done_q) // [RL6]
    else $error("control write did not clear done");

  chan_restart_a: assert property (chan_change && running |=> sample_hold && dac_code == 10'h000 ##1 !conv_done) // [RL8]
    else $error("channel change did not restart sampling");

  off_stops_a: assert property (!on_q |-> !converter_power ##1 (!sample_hold && !conv_done)) // [RL4]
    else $error("converter still active while off");

  // Speed may change right after a tick, so the gap is only judged while it stays at four
  div4_gap_a: assert property (tick && !speed_q ##1 !speed_q [*3] |-> !$past(tick, 2) && !$past(tick) && !tick) // [RL9]
    else $error("divide-by-four tick spacing wrong");

  div2_rate_a: assert property (tick && speed_q && $stable(speed_q) ##1 (running && speed_q) [*2] |-> tick) // [RL9]
    else $error("divide-by-two tick spacing wrong");

  high_map_a: assert property (setup && !pwrite && hit_high |=> prdata == {24'h000000, $past(res_q[9:2])}) // [RL12]
    else $error("high result read mismatch");

  low_map_a: assert property (setup && !pwrite && hit_low |=> prdata[31:2] == 30'h00000000 && prdata[1:0] == $past(res_q[1:0])) // [RL13]
    else $error("low result read mismatch");

  halt_wait_a: assert property ($fell(halt_mode) |-> !running [*8]) // [RL16]
    else $error("conversion resumed without stabilisation wait");

  continuous_a: assert property (conv_done && running |-> sample_hold) // [RL3]
    else $error("converter did not resume sampling after a conversion");

  unmapped_err_a: assert property (access && !mapped |-> pslverr && pready)
    else $error("unmapped access not flagged");

  conv_done_c: cover property (conv_done ##[1:40] rd_high);
  chan_change_c: cover property (running && chan_change);
  halt_exit_c: cover property ($fell(halt_mode) ##[1:400] running);
  set_wins_c: cover property (conv_done && wr_ctrl);

endmodule

// file: tb/sar_adc_control_tb.sv
/*
  Self-checking bench for sar_adc_control: APB master tasks, a comparator
  model and one task per scenario.
  Assumes the conv_pkg constants and the zero-wait APB slave of the design.
*/
`timescale 1ns/1ps
module sar_adc_control_tb
  import conv_pkg::*;
;
  localparam logic [11:0] A_CTRL = {IDX_CTRL, 2'b00};
  localparam logic [11:0] A_HIGH = {IDX_HIGH, 2'b00};
  localparam logic [11:0] A_LOW = {IDX_LOW, 2'b00};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic halt_mode = 1'b0;
  logic comp_above = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic converter_power;
  logic [SEL_W-1:0] input_select;
  logic sample_hold;
  logic [RES_W-1:0] dac_code;
  logic [RES_W-1:0] vin = 10'h000;
  logic [7:0] rd;
  logic er;
  int mismatches = 0;
  int checks_done = 0;

  always #50 pclk = ~pclk;

  // Comparator model; a clocked macro, so it lags the trial code by one pclk
  always @(posedge pclk) begin
    comp_above <= (vin >= dac_code);
  end

  sar_adc_control dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .halt_mode(halt_mode),
    .comp_above(comp_above), .converter_power(converter_power),
    .input_select(input_select), .sample_hold(sample_hold), .dac_code(dac_code)
  );

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One APB transfer; request held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk("pready", 32'h1, 32'(pready));
    rd = prdata[7:0];
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Poll the done flag; reading control never clears it
  task automatic wait_done(input int lim);
    int n;
    n = 0;
    rd = 8'h00;
    while (rd[DONE_BIT] !== 1'b1 && n < lim) begin
      apb(1'b0, A_CTRL, 8'h00);
      n++;
    end
    chk("done seen", 32'h1, 32'(rd[DONE_BIT]));
  endtask

  task automatic wait_sh(input logic lvl);
    int n;
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (sample_hold !== lvl && n < 200);
    chk("sample_hold level", 32'(lvl), 32'(sample_hold));
  endtask

  // First result after a level change may mix old and new input, so skip it
  task automatic conv_check(input logic [RES_W-1:0] v);
    vin <= v;
    wait_done(60);
    apb(1'b0, A_HIGH, 8'h00);
    wait_done(60);
    apb(1'b0, A_LOW, 8'h00);
    chk("low result", {30'h0, v[1:0]}, {24'h0, rd});
    apb(1'b0, A_HIGH, 8'h00);
    chk("high result", {24'h0, v[9:2]}, {24'h0, rd});
    apb(1'b0, A_CTRL, 8'h00);
    chk("done after high read", 32'h0, 32'(rd[DONE_BIT]));
  endtask

  task automatic t_reset;
    apb(1'b0, A_CTRL, 8'h00);
    chk("ctrl after reset", 32'h0, {24'h0, rd});
    apb(1'b0, A_HIGH, 8'h00);
    chk("high after reset", 32'h0, {24'h0, rd});
    apb(1'b0, 12'h1CC, 8'h00);
    chk("unmapped error", 32'h1, 32'(er));
    chk("unmapped data", 32'h0, {24'h0, rd});
  endtask

  task automatic t_convert;
    apb(1'b1, A_CTRL, 8'h65);
    // The write lands at the access edge; look once it has settled
    @(negedge pclk);
    chk("power on", 32'h1, 32'(converter_power));
    conv_check(10'h3FF);
    conv_check(10'h000);
    conv_check(10'h2A7);
  endtask

  // Sampling lasts three converter clocks at either rate
  task automatic t_speed;
    int n;
    for (int s = 0; s < 2; s++) begin
      apb(1'b1, A_CTRL, {1'b0, s[0], 6'h20});
      wait_sh(1'b0);
      wait_sh(1'b1);
      n = 0;
      while (sample_hold === 1'b1 && n < 100) begin
        @(negedge pclk);
        n++;
      end
      chk("sampling length", (s == 1) ? 32'd6 : 32'd12, n);
    end
  endtask

  task automatic t_write_clear;
    wait_done(60);
    apb(1'b1, A_CTRL, 8'h60);
    apb(1'b0, A_CTRL, 8'h00);
    chk("done after ctrl write", 32'h0, 32'(rd[DONE_BIT]));
    chk("ctrl readback", 32'h60, {24'h0, rd});
  endtask

  // Walk all inputs, then switch input just as a conversion starts deciding
  task automatic t_channel;
    for (int c = 0; c < 16; c++) begin
      apb(1'b1, A_CTRL, {4'h6, c[3:0]});
      @(negedge pclk);
      chk("input select", 32'(c), {28'h0, input_select});
    end
    wait_sh(1'b1);
    wait_sh(1'b0);
    apb(1'b1, A_CTRL, 8'h69);
    @(posedge pclk);
    @(negedge pclk);
    chk("restart sampling", 32'h1, 32'(sample_hold));
    apb(1'b0, A_CTRL, 8'h00);
    chk("done after switch", 32'h0, 32'(rd[DONE_BIT]));
  endtask

  task automatic t_off;
    logic [7:0] h;
    apb(1'b1, A_CTRL, 8'h49);
    @(negedge pclk);
    chk("power off", 32'h0, 32'(converter_power));
    apb(1'b0, A_HIGH, 8'h00);
    h = rd;
    apb(1'b1, A_HIGH, 8'h55);
    chk("result write error", 32'h0, 32'(er));
    repeat (60) @(posedge pclk);
    apb(1'b0, A_CTRL, 8'h00);
    chk("ctrl while off", 32'h49, {24'h0, rd});
    apb(1'b0, A_HIGH, 8'h00);
    chk("high kept", {24'h0, h}, {24'h0, rd});
  endtask

  // Stabilisation after halt is 300 pclk; probe 290 of them
  task automatic t_halt;
    int n;
    apb(1'b1, A_CTRL, 8'h69);
    wait_sh(1'b1);
    @(posedge pclk);
    halt_mode <= 1'b1;
    @(negedge pclk);
    chk("power in halt", 32'h0, 32'(converter_power));
    repeat (10) @(posedge pclk);
    halt_mode <= 1'b0;
    n = 0;
    repeat (290) begin
      @(negedge pclk);
      if (sample_hold === 1'b1) begin
        n++;
      end
    end
    chk("power after halt", 32'h1, 32'(converter_power));
    chk("sampling in wait", 32'h0, n);
    wait_done(150);
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_convert;
    t_speed;
    t_write_clear;
    t_channel;
    t_off;
    t_halt;
    report_and_stop;
  end

  // Watchdog; the whole sequence needs well under 8000 cycles
  initial begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    report_and_stop;
  end
endmodule
